//--- rtl/rfai_edge.sv
// module: change detector for the three alarm levels
`timescale 1ns/10ps
`default_nettype none
module rfai_edge #(
  parameter int WIDTH = 3
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] level_in,
  output var logic [WIDTH-1:0] change_out
);

  typedef struct packed {
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] change;
  } rfai_edge_state_t;

  rfai_edge_state_t st;
  rfai_edge_state_t next_st;

  // ----------------------------------------
  // declare or clear both count as change
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.prev = level_in;
    next_st.change = level_in ^ st.prev;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign change_out = st.change;

endmodule
`default_nettype wire

//--- rtl/rfai_pkg.sv
// package: register map, field positions and types for the framer alarm interrupt block
package rfai_pkg;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] OFF_ALARM_ERROR_INT_ENABLE = 12'h000;
  localparam logic [11:0] OFF_FRAMER_INT_STATUS = 12'h004;
  localparam logic [11:0] OFF_FRAMER_INT_ENABLE = 12'h008;
  localparam logic [11:0] OFF_EVENT_STATUS = 12'h00c;
  localparam logic [11:0] OFF_EVENT_MASK = 12'h010;
  localparam logic [11:0] OFF_LIVE_STATE = 12'h014;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_YEL_ENB = 0;
  localparam int BIT_AIS_ENB = 1;
  localparam int BIT_LOF_ALM_ENB = 2;
  localparam int BIT_LOF_FLAG = 3;
  localparam int BIT_FRAME_ALIGNMENT_MOVE_FLAG_FLAG = 4;
  localparam int BIT_SIG_FLAG = 5;
  localparam int EVT_YEL = 0;
  localparam int EVT_AIS = 1;
  localparam int EVT_LOF = 2;
  localparam int EVT_FRAME_ALIGNMENT_MOVE_FLAG = 3;
  localparam int EVT_SIG = 4;
  localparam int EVT_W = 5;

  // ----------------------------------------
  // reset values and masks
  // ----------------------------------------
  localparam logic [7:0] RST_ALARM_ERROR_INT_ENABLE = 8'h00;
  localparam logic [7:0] RST_FRAMER_INT_ENABLE = 8'h00;
  localparam logic [7:0] RST_FRAMER_INT_STATUS = 8'h00;
  localparam logic [4:0] RST_EVENT = 5'h00;
  localparam logic [7:0] MASK_ALARM_ENABLE = 8'h07;
  localparam logic [7:0] MASK_FRAMER_FIELDS = 8'h38;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic rx_ais;
    logic rx_yel;
    logic rx_lof;
    logic frame_alignment_move_flag_pulse;
    logic sig_pulse;
    logic rbs_enable;
  } rfai_framer_t;

  typedef enum logic [1:0] {
    RFAI_IDLE = 2'b00,
    RFAI_SETUP = 2'b01,
    RFAI_ACCESS = 2'b11
  } rfai_phase_t;

endpackage

//--- rtl/rfai_top.sv
// module: receive framer alarm and framer interrupt registers with apb access
`timescale 1ns/10ps
`default_nettype none
module rfai_top (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  input wire rfai_pkg::rfai_framer_t FRAMER_IN,
  output var logic [31:0] PRDATA_OUT,
  output var logic PREADY_OUT,
  output var logic PSLVERR_OUT,
  output var logic IRQ_OUT,
  output var logic ALARM_IRQ_OUT
);

  typedef struct packed {
    logic [7:0] alarm_error_int_enable;
    logic [7:0] framer_int_enable;
    logic [7:0] framer_int_status;
    logic [4:0] event_status;
    logic [4:0] event_mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic alarm_irq;
  } rfai_state_t;

  rfai_state_t st;
  rfai_state_t next_st;
  logic [2:0] alarm_change;

  // ----------------------------------------
  // alarm change detection
  // ----------------------------------------
  rfai_edge #(
    .WIDTH(3)
  ) u_edge (
    .clk_in(CLK_IN),
    .nrst_in(NRST_IN),
    .level_in({FRAMER_IN.rx_lof, FRAMER_IN.rx_ais, FRAMER_IN.rx_yel}),
    .change_out(alarm_change)
  );

  function automatic logic [31:0] rfai_word(input logic [7:0] v);
    rfai_word = {24'h00_0000, v};
  endfunction

  function automatic logic rfai_hit(input logic [11:0] a, input logic [11:0] off);
    rfai_hit = (a == off);
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic access;
    logic rd;
    logic wr;
    logic [7:0] wbyte;
    logic [7:0] set_status;
    logic [4:0] set_event;
    logic [7:0] clr_status;
    logic [4:0] clr_event;
    logic [7:0] alarm_pend;
    logic [7:0] framer_pend;
    access = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    wbyte = 8'h00;
    set_status = 8'h00;
    set_event = 5'h00;
    clr_status = 8'h00;
    clr_event = 5'h00;
    alarm_pend = 8'h00;
    framer_pend = 8'h00;
    next_st = st;
    access = PSEL_IN && PENABLE_IN && !st.pready;
    rd = access && !PWRITE_IN;
    wr = access && PWRITE_IN;
    wbyte = PSTRB_IN[0] ? PWDATA_IN[7:0] : 8'h00;
    next_st.pready = access;
    next_st.pslverr = 1'b0;
    next_st.prdata = rfai_pkg::RDATA_ZERO;
    // event sources
    set_status[rfai_pkg::BIT_LOF_FLAG] = alarm_change[2];
    set_status[rfai_pkg::BIT_FRAME_ALIGNMENT_MOVE_FLAG_FLAG] = FRAMER_IN.frame_alignment_move_flag_pulse;
    set_status[rfai_pkg::BIT_SIG_FLAG] = FRAMER_IN.sig_pulse && FRAMER_IN.rbs_enable;
    set_event[rfai_pkg::EVT_YEL] = alarm_change[0];
    set_event[rfai_pkg::EVT_AIS] = alarm_change[1];
    set_event[rfai_pkg::EVT_LOF] = alarm_change[2];
    set_event[rfai_pkg::EVT_FRAME_ALIGNMENT_MOVE_FLAG] = FRAMER_IN.frame_alignment_move_flag_pulse;
    set_event[rfai_pkg::EVT_SIG] = set_status[rfai_pkg::BIT_SIG_FLAG];
    if (access) begin
      if (rfai_hit(PADDR_IN, rfai_pkg::OFF_ALARM_ERROR_INT_ENABLE)) begin
        if (wr) begin
          next_st.alarm_error_int_enable = wbyte & rfai_pkg::MASK_ALARM_ENABLE;
        end
        next_st.prdata = rfai_word(st.alarm_error_int_enable);
      end else if (rfai_hit(PADDR_IN, rfai_pkg::OFF_FRAMER_INT_STATUS)) begin
        next_st.prdata = rfai_word(st.framer_int_status);
        if (rd) begin
          clr_status = st.framer_int_status;
        end else begin
          clr_status = wbyte & rfai_pkg::MASK_FRAMER_FIELDS;
        end
      end else if (rfai_hit(PADDR_IN, rfai_pkg::OFF_FRAMER_INT_ENABLE)) begin
        if (wr) begin
          next_st.framer_int_enable = wbyte & rfai_pkg::MASK_FRAMER_FIELDS;
        end
        next_st.prdata = rfai_word(st.framer_int_enable);
      end else if (rfai_hit(PADDR_IN, rfai_pkg::OFF_EVENT_STATUS)) begin
        if (wr) begin
          clr_event = wbyte[4:0];
        end
        next_st.prdata = rfai_word({3'h0, st.event_status});
      end else if (rfai_hit(PADDR_IN, rfai_pkg::OFF_EVENT_MASK)) begin
        if (wr) begin
          next_st.event_mask = wbyte[4:0];
        end
        next_st.prdata = rfai_word({3'h0, st.event_mask});
      end else if (rfai_hit(PADDR_IN, rfai_pkg::OFF_LIVE_STATE)) begin
        next_st.prdata = rfai_word({2'h0, FRAMER_IN.rbs_enable, 2'h0,
          FRAMER_IN.rx_lof, FRAMER_IN.rx_ais, FRAMER_IN.rx_yel});
      end else begin
        next_st.pslverr = 1'b1;
      end
    end
    // set wins over clear
    next_st.framer_int_status = ((st.framer_int_status & ~clr_status) | set_status)
      & rfai_pkg::MASK_FRAMER_FIELDS;
    next_st.event_status = (st.event_status & ~clr_event) | set_event;
    // interrupt request
    alarm_pend = 8'h00;
    alarm_pend[rfai_pkg::BIT_YEL_ENB] = st.event_status[rfai_pkg::EVT_YEL];
    alarm_pend[rfai_pkg::BIT_AIS_ENB] = st.event_status[rfai_pkg::EVT_AIS];
    alarm_pend[rfai_pkg::BIT_LOF_ALM_ENB] = st.event_status[rfai_pkg::EVT_LOF];
    framer_pend = next_st.framer_int_status & st.framer_int_enable;
    next_st.alarm_irq = |(alarm_pend & st.alarm_error_int_enable);
    next_st.irq = |framer_pend || next_st.alarm_irq
      || |(st.event_status & st.event_mask & 5'h18);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      st <= '0;
      st.alarm_error_int_enable <= rfai_pkg::RST_ALARM_ERROR_INT_ENABLE;
      st.framer_int_enable <= rfai_pkg::RST_FRAMER_INT_ENABLE;
      st.framer_int_status <= rfai_pkg::RST_FRAMER_INT_STATUS;
      st.event_status <= rfai_pkg::RST_EVENT;
      st.event_mask <= rfai_pkg::RST_EVENT;
    end else begin
      st <= next_st;
    end
  end

  assign PRDATA_OUT = st.prdata;
  assign PREADY_OUT = st.pready;
  assign PSLVERR_OUT = st.pslverr;
  assign IRQ_OUT = st.irq;
  assign ALARM_IRQ_OUT = st.alarm_irq;

endmodule
`default_nettype wire

//--- tb/rfai_top_sva.sv
// checker: port-level assertions for the framer alarm interrupt block
`timescale 1ns/10ps
`default_nettype none
module rfai_top_sva (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  input wire rfai_pkg::rfai_framer_t FRAMER_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic IRQ_OUT,
  input wire logic ALARM_IRQ_OUT
);
  logic [2:0] en;
  logic take;
  // ----------------------------------------
  // tracked alarm enables
  // ----------------------------------------
  assign take = PSEL_IN && PENABLE_IN && !PREADY_OUT;
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN)
      en <= 3'h0;
    else if (take && PWRITE_IN && PADDR_IN == rfai_pkg::OFF_ALARM_ERROR_INT_ENABLE)
      en <= PWDATA_IN[2:0] & {3{PSTRB_IN[0]}};
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  property p_ais; $changed(FRAMER_IN.rx_ais) && en[1] |-> ##[1:5] ALARM_IRQ_OUT; endproperty
  a_ais: assert property (p_ais) else $error("ais change no irq");
  property p_yel; $changed(FRAMER_IN.rx_yel) && en[0] |-> ##[1:5] ALARM_IRQ_OUT; endproperty
  a_yel: assert property (p_yel) else $error("yellow change no irq");
  property p_lof; $changed(FRAMER_IN.rx_lof) && en[2] |-> ##[1:5] ALARM_IRQ_OUT; endproperty
  a_lof: assert property (p_lof) else $error("lof change no irq");
  property p_hold; ALARM_IRQ_OUT && !PSEL_IN && !$past(PSEL_IN) |=> ALARM_IRQ_OUT; endproperty
  a_hold: assert property (p_hold) else $error("irq dropped");
  property p_gate; ALARM_IRQ_OUT |-> |{en, $past(en), $past(en, 2)}; endproperty
  a_gate: assert property (p_gate) else $error("irq while disabled");
  property p_resv; PREADY_OUT && PADDR_IN == 12'h004 |-> PRDATA_OUT[7:6] == 2'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_rdy; take |=> PREADY_OUT ##1 !PREADY_OUT; endproperty
  a_rdy: assert property (p_rdy) else $error("bad ready");
  property p_err; PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error answer");
endmodule
bind rfai_top rfai_top_sva chk (.*);
`default_nettype wire

//--- tb/rx_framer_alarm_interrupts_bench.sv
// testbench: apb scenarios for the framer alarm interrupt block
`timescale 1ns/10ps
`default_nettype none
module rx_framer_alarm_interrupts_bench;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd, rd;
  logic rdy, perr, er, irq, airq;
  rfai_pkg::rfai_framer_t fr = '0;
  int n_errors = 0;
  int check_count = 0;
  int cyc_n = 0;
  rfai_top dut (.CLK_IN(clk_in), .NRST_IN(nrst_in), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PSTRB_IN(4'hf), .FRAMER_IN(fr),
    .PRDATA_OUT(prd), .PREADY_OUT(rdy), .PSLVERR_OUT(perr), .IRQ_OUT(irq),
    .ALARM_IRQ_OUT(airq));
  // ----------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------
  initial forever #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 2000) begin
      n_errors++;
      complete_run();
    end
  end
  task complete_run;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    do @(posedge clk_in); while (rdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_in);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    apb(0, 12'h000, 0); chk(rd, 32'h0);
    apb(0, 12'h004, 0); chk(rd, 32'h0);
    apb(0, 12'h020, 0); chk(rd, 32'h0);
    chk(er, 1'b1);
    apb(1, 12'h000, 32'hff); apb(0, 12'h000, 0); chk(rd, 32'h7);
  endtask
  task t_alarm;
    fr <= 6'b111000;
    cyc(8); chk(airq, 1'b1);
    apb(0, 12'h014, 0); chk(rd, 32'h7);
    apb(0, 12'h00c, 0); chk(rd, 32'h7);
    apb(0, 12'h004, 0); chk(rd, 32'h8);
    apb(0, 12'h004, 0); chk(rd, 32'h0);
    apb(1, 12'h00c, 32'h7); cyc(4); chk(airq, 1'b0);
    fr <= 6'b000000;
    cyc(8); apb(0, 12'h00c, 0); chk(rd, 32'h7);
    apb(0, 12'h004, 0); chk(rd, 32'h8);
    apb(1, 12'h00c, 32'h7); apb(1, 12'h000, 32'h0);
    fr <= 6'b110000;
    cyc(8); chk(airq, 1'b0);
    fr <= 6'b000000;
    cyc(8); apb(1, 12'h00c, 32'h1f); apb(0, 12'h004, 0);
  endtask
  task t_frm;
    fr <= 6'b000010;
    cyc(1); fr <= 6'b000000;
    cyc(3); apb(0, 12'h004, 0); chk(rd, 32'h0);
    apb(1, 12'h008, 32'h38); apb(1, 12'h00c, 32'h1f);
    fr <= 6'b000111;
    cyc(1); fr <= 6'b000001;
    cyc(4); chk(irq, 1'b1);
    apb(0, 12'h004, 0); chk(rd, 32'h30);
    apb(0, 12'h004, 0); chk(rd, 32'h0);
    apb(1, 12'h00c, 32'h1f); cyc(4); chk(irq, 1'b0);
    // channel lookup is left to software reading change registers
    apb(1, 12'h008, 32'h0); apb(1, 12'h010, 32'h18);
    fr <= 6'b000100;
    cyc(1); fr <= 6'b000000;
    cyc(4); chk(irq, 1'b1);
    apb(0, 12'h00c, 0); chk(rd, 32'h8);
    apb(1, 12'h00c, 32'h8); apb(0, 12'h004, 0);
    cyc(4); chk(irq, 1'b0);
  endtask
  initial begin
    cyc(16);
    nrst_in <= 1'b1;
    cyc(1);
    t_regs();
    t_alarm();
    t_frm();
    complete_run();
  end
endmodule
`default_nettype wire
